// ===== design/disk_fifo_dma_sequencer.sv
// Function
// - Inputs and control outputs are registered, stable one T-state of at least 125 ns; FIFO flags are not registered, FIFO strobes and launch last one clock.
// - Illegal inputs set error, freeze status, interrupt host; ignored while idle.
// - Rest in idle after reset and after a completed transfer.
// - Start command moves idle to wait-for-FIFO until FIFO ready.
// - FIFO unavailable: full when reading memory, empty when writing.
// - FIFO available raises hold request, then await grant before cycles.
// - After grant: start state, then T1, T2, T3, T4.
// - Memory ready low inserts wait states after T3 until high.
// - Last word at T4 drops hold, signals completion, highest priority.
// - Words left, FIFO ready, no other master: straight to T1.
// - FIFO unavailable or other master: drop hold, back to FIFO wait.
// - Unused state flags error, interrupts, returns idle, status frozen.
// - Grant dropped mid-transfer: vacate bus by dropping hold request.
// - T1 drives full 24-bit word address on bus.
// - FIFO to memory: prefetch at T1, drive data T2, T3, waits.
// - Memory to FIFO: read memory, write word to FIFO at T4.
// - Each word increments count and 24-bit address.
// - Grant drop: drop hold, wait two states, request again.
// - End of transfer interrupts host and returns idle.
// - Run flag high from start until the transfer completes or an error aborts it.
// - One transfer moves at most 256 words.
//
// The register addresses and the AXI4-Lite slave port were decided locally.
`include "disk_dma_params.svh"

module disk_fifo_dma_sequencer
  import disk_dma_pkg::*;
#(
  parameter int TICK_CYCLES = `TSTATE_CYCLES
)
(
  // Clock and reset
  input  wire logic                        mclk_i,
  input  wire logic                        rst_n_i,
  // AXI4-Lite write address and data
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [7:0]                  s_axi_awaddr,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  // AXI4-Lite write response
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  output logic [1:0]                       s_axi_bresp,
  // AXI4-Lite read
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  input  wire logic [7:0]                  s_axi_araddr,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  // Arbiter and memory
  output logic                             bus_hold_request_o,
  input  wire logic                        bus_hold_grant_i,
  input  wire logic                        other_master_req_i,
  input  wire logic                        memory_ready_in_i,
  // Multiplexed host bus
  output disk_dma_pkg::host_bus_out_t      host_bus_o,
  input  wire logic [15:0]                 ad_i,
  // Disk FIFO
  input  wire logic                        fifo_full_i,
  input  wire logic                        fifo_empty_i,
  input  wire logic [15:0]                 fifo_rdata_i,
  output disk_dma_pkg::fifo_ctl_t          fifo_o,
  // Host notification
  output logic                             launch_transfer_cmd_o,
  output logic                             transfer_running_flag_o,
  output logic                             host_irq_o
);
  import disk_dma_pkg::*;

  core_t r_reg;
  core_t r_next;

  // Bus pins for a given state; data comes from registers only
  function automatic host_bus_out_t bus_for(seq_state_t st, logic dir,
                                            logic [23:0] addr,
                                            logic [15:0] data);
    host_bus_out_t b;
    logic          act;
    act = (st == ST_T1 || st == ST_T2 || st == ST_T3 || st == ST_WAIT);
    b.addr_data_n = (st != ST_T1);
    b.addr_hi     = b.addr_data_n ? 8'h00 : addr[23:16];
    b.ad    = !act ? 16'h0000 : b.addr_data_n ? data : addr[15:0];
    b.ad_oe = act & (~dir | ~b.addr_data_n);
    b.status_lines = !act ? `SLINES_PASSIVE :
                     dir ? `SLINES_MEM_READ : `SLINES_MEM_WRITE;
    return b;
  endfunction : bus_for

  // Byte-lane merge of a write onto a stored word
  function automatic logic [31:0] merge(logic [31:0] old_v,
                                        logic [31:0] new_v,
                                        logic [3:0]  strb);
    logic [31:0] m;
    m = old_v;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        m[8*i +: 8] = new_v[8*i +: 8];
    return m;
  endfunction : merge

  logic        tick;
  logic        fifo_avail;
  logic        illegal_in;
  logic        wr_fire;
  logic [31:0] merged;

  // One T-state every TICK_CYCLES clocks
  // State stepping enable
  assign tick = (r_reg.tick_cnt == 4'(TICK_CYCLES - 1));

  assign fifo_avail = r_reg.dir ? ~fifo_full_i : ~fifo_empty_i;

  // Full and empty together cannot be true
  assign illegal_in = fifo_full_i & fifo_empty_i;

  assign wr_fire = r_reg.aw_full & r_reg.w_full & ~r_reg.bvalid;

  always_comb
  begin
    merged = 32'h0000_0000;
    r_next = r_reg;
    r_next.launch  = 1'b0;
    r_next.fifo.rd = 1'b0;
    r_next.fifo.wr = 1'b0;

    // Two-flop synchronisers for pins
    r_next.grant_s1 = bus_hold_grant_i;
    r_next.grant_s2 = r_reg.grant_s1;
    r_next.rdy_s1   = memory_ready_in_i;
    r_next.rdy_s2   = r_reg.rdy_s1;
    r_next.other_s1 = other_master_req_i;
    r_next.other_s2 = r_reg.other_s1;

    r_next.tick_cnt = tick ? 4'h0 : r_reg.tick_cnt + 4'h1;

    // Write address and data taken in either order
    if (s_axi_awvalid && !r_reg.aw_full)
    begin
      r_next.aw_full = 1'b1;
      r_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r_reg.w_full)
    begin
      r_next.w_full = 1'b1;
      r_next.wdata  = s_axi_wdata;
      r_next.wstrb  = s_axi_wstrb;
    end

    // Software clear comes first so a same-cycle event still sets
    if (wr_fire && r_reg.aw_addr == `REG_CTRL_OFS && r_reg.wstrb[0] &&
        r_reg.wdata[`CTRL_CLEAR_BIT])
    begin
      r_next.err  = 1'b0;
      r_next.done = 1'b0;
    end

    if (wr_fire)
    begin
      r_next.aw_full = 1'b0;
      r_next.w_full  = 1'b0;
      r_next.bvalid  = 1'b1;
      r_next.bresp   = `RESP_OKAY;
      case (r_reg.aw_addr)
        `REG_CTRL_OFS:
          // Direction is locked while a transfer runs
          if (r_reg.wstrb[0] && !r_reg.run)
          begin
            r_next.dir = r_reg.wdata[`CTRL_DIR_BIT];
            if (r_reg.wdata[`CTRL_START_BIT] && !r_reg.err)
              r_next.start_pend = 1'b1;
          end
        `REG_COUNT_OFS:
          if (!r_reg.run)
          begin
            merged = merge({16'h0000, r_reg.count}, r_reg.wdata,
                           r_reg.wstrb);
            r_next.count = merged[15:0];
          end
        `REG_ADDR_OFS:
          if (!r_reg.run)
          begin
            merged = merge({8'h00, r_reg.addr}, r_reg.wdata, r_reg.wstrb);
            r_next.addr = merged[23:0];
          end
        default: r_next.bresp = `RESP_SLVERR;
      endcase
    end
    if (r_reg.bvalid && s_axi_bready)
      r_next.bvalid = 1'b0;

    // Read answer one cycle after the address is taken
    if (s_axi_arvalid && !r_reg.rvalid)
    begin
      r_next.rvalid = 1'b1;
      r_next.rresp  = `RESP_OKAY;
      case (s_axi_araddr)
        `REG_CTRL_OFS:   r_next.rdata = {31'h0, r_reg.dir};
        `REG_COUNT_OFS:  r_next.rdata = {16'h0000, r_reg.count};
        `REG_ADDR_OFS:   r_next.rdata = {8'h00, r_reg.addr};
        `REG_STATUS_OFS: r_next.rdata = {23'h0, r_reg.err, r_reg.snap};
        default:
        begin
          r_next.rdata = 32'h0000_0000;
          r_next.rresp = `RESP_SLVERR;
        end
      endcase
    end
    else if (r_reg.rvalid && s_axi_rready)
      r_next.rvalid = 1'b0;

    // Sequencer steps once per T-state
    if (tick)
    begin
      case (r_reg.st)
        ST_IDLE:
        begin
          if (r_reg.start_pend)
          begin
            r_next.start_pend = 1'b0;
            // Zero or over-long count is refused as an error
            if (r_reg.count == 16'h0000 || r_reg.count < `MAX_WORDS_NEG)
              r_next.err = 1'b1;
            else
            begin
              r_next.run    = 1'b1;
              r_next.launch = 1'b1;
              r_next.st     = ST_WAIT_FIFO;
            end
          end
        end
        ST_WAIT_FIFO:
        begin
          // Request bus once FIFO is ready
          if (fifo_avail)
          begin
            r_next.hold = 1'b1;
            r_next.st   = ST_HOLD;
          end
        end
        ST_HOLD:
        begin
          // No bus cycle before the grant
          if (r_reg.grant_s2)
            r_next.st = ST_START;
        end
        ST_START: r_next.st = ST_T1;
        ST_T1:
        begin
          if (!r_reg.dir)
          begin
            r_next.data    = fifo_rdata_i;
            r_next.fifo.rd = 1'b1;
          end
          r_next.st = ST_T2;
        end
        ST_T2:    r_next.st = ST_T3;
        ST_T3, ST_WAIT:
        begin
          // Wait states while memory not ready
          if (r_reg.rdy_s2)
          begin
            r_next.st = ST_T4;
            // Capture memory word, write FIFO at T4
            if (r_reg.dir)
            begin
              r_next.data       = ad_i;
              r_next.fifo.wr    = 1'b1;
              r_next.fifo.wdata = ad_i;
            end
          end
          else
            r_next.st = ST_WAIT;
        end
        ST_T4:
        begin
          // Count and address advance per word
          r_next.count = r_reg.count + 16'h0001;
          r_next.addr  = r_reg.addr + 24'h000001;
          if (r_reg.count == 16'hffff)
          begin
            // End of transfer wins over all else
            r_next.hold = 1'b0;
            r_next.done = 1'b1;
            r_next.run  = 1'b0;
            r_next.st   = ST_IDLE;
          end
          else if (!r_reg.grant_s2)
          begin
            r_next.hold = 1'b0;
            r_next.st   = ST_REL1;
          end
          else if (!fifo_avail || r_reg.other_s2)
          begin
            // Release bus and wait for FIFO
            r_next.hold = 1'b0;
            r_next.st   = ST_WAIT_FIFO;
          end
          // Keep the bus for the next word
          else
            r_next.st = ST_T1;
        end
        ST_REL1:  r_next.st = ST_REL2;
        ST_REL2:
        begin
          if (fifo_avail)
          begin
            r_next.hold = 1'b1;
            r_next.st   = ST_HOLD;
          end
          else
            r_next.st = ST_WAIT_FIFO;
        end
        default:
        begin
          r_next.err  = 1'b1;
          r_next.hold = 1'b0;
          r_next.run  = 1'b0;
          r_next.st   = ST_IDLE;
        end
      endcase

      // Illegal FIFO status aborts to idle
      if (illegal_in && r_reg.st != ST_IDLE)
      begin
        r_next.err  = 1'b1;
        r_next.hold = 1'b0;
        r_next.run  = 1'b0;
        r_next.st   = ST_IDLE;
      end
    end

    // Status snapshot frozen while error stands
    if (!r_next.err)
      r_next.snap = {r_next.st, r_next.hold, r_next.done, r_next.run,
                     r_next.dir};

    r_next.bus = bus_for(r_next.st, r_next.dir, r_next.addr, r_next.data);
  end

  // Single register stage for the whole state
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      r_reg          <= '0;
      r_reg.st       <= ST_IDLE;
      r_reg.dir      <= `CTRL_RST;
      r_reg.count    <= `COUNT_RST;
      r_reg.addr     <= `ADDR_RST;
      r_reg.bus      <= bus_for(ST_IDLE, 1'b0, 24'h000000, 16'h0000);
    end
    else
      r_reg <= r_next;
  end

  // Handshake outputs
  assign s_axi_awready = ~r_reg.aw_full;
  assign s_axi_wready  = ~r_reg.w_full;
  assign s_axi_bvalid  = r_reg.bvalid;
  assign s_axi_bresp   = r_reg.bresp;
  assign s_axi_arready = ~r_reg.rvalid;
  assign s_axi_rvalid  = r_reg.rvalid;
  assign s_axi_rdata   = r_reg.rdata;
  assign s_axi_rresp   = r_reg.rresp;

  // Pin and host outputs, all from flops
  assign bus_hold_request_o      = r_reg.hold;
  assign host_bus_o              = r_reg.bus;
  assign fifo_o                  = r_reg.fifo;
  assign launch_transfer_cmd_o   = r_reg.launch;
  assign transfer_running_flag_o = r_reg.run;
  // Level until software clears, done or error alike
  assign host_irq_o              = r_reg.done | r_reg.err;

endmodule : disk_fifo_dma_sequencer

// ===== design/disk_dma_params.svh
`ifndef DISK_DMA_PARAMS_SVH
`define DISK_DMA_PARAMS_SVH

// Register byte offsets on the AXI4-Lite slave
`define REG_CTRL_OFS      8'h00
`define REG_COUNT_OFS     8'h04
`define REG_ADDR_OFS      8'h08
`define REG_STATUS_OFS    8'h0c

// Control register fields
`define CTRL_DIR_BIT      0
`define CTRL_START_BIT    1
`define CTRL_CLEAR_BIT    2

// Status register fields
`define STAT_ERR_BIT      8

// Reset values
`define CTRL_RST          1'b0
`define COUNT_RST         16'h0000
`define ADDR_RST          24'h000000

// Largest legal transfer, as a two's complement word count
`define MAX_WORDS_NEG     16'hff00

// Bus status line encodings
`define SLINES_MEM_READ   3'h5
`define SLINES_MEM_WRITE  3'h6
`define SLINES_PASSIVE    3'h7

// AXI responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

// One bus T-state lasts at least this long
`define TSTATE_NS         125
`define MCLK_PERIOD_NS    40
`define TSTATE_CYCLES     ((`TSTATE_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)

`endif

// ===== design/disk_dma_pkg.sv
package disk_dma_pkg;

  // Sequencer states
  typedef enum logic [3:0]
  {
    ST_IDLE,
    ST_WAIT_FIFO,
    ST_HOLD,
    ST_START,
    ST_T1,
    ST_T2,
    ST_T3,
    ST_WAIT,
    ST_T4,
    ST_REL1,
    ST_REL2
  } seq_state_t;

  // Pins driven onto the multiplexed host bus
  typedef struct packed {
    logic [15:0] ad;
    logic        ad_oe;
    logic [7:0]  addr_hi;
    logic [2:0]  status_lines;
    logic        addr_data_n;
  } host_bus_out_t;

  // FIFO strobes and write data
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] wdata;
  } fifo_ctl_t;

  // Whole state of the sequencer and its register slave
  typedef struct packed {
    seq_state_t    st;
    logic [3:0]    tick_cnt;
    logic          dir;
    logic          start_pend;
    logic [15:0]   count;
    logic [23:0]   addr;
    logic [15:0]   data;
    logic          run;
    logic          done;
    logic          err;
    logic [7:0]    snap;
    logic          hold;
    logic          launch;
    fifo_ctl_t     fifo;
    host_bus_out_t bus;
    logic          aw_full;
    logic [7:0]    aw_addr;
    logic          w_full;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          rvalid;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
    logic          grant_s1;
    logic          grant_s2;
    logic          rdy_s1;
    logic          rdy_s2;
    logic          other_s1;
    logic          other_s2;
  } core_t;

endpackage : disk_dma_pkg

// ===== verification/disk_dma_seq_assertions.sv
`include "disk_dma_params.svh"

module disk_dma_seq_assertions
  import disk_dma_pkg::*;
#(
  parameter int TICK_CYCLES = 4
)
(
  // Clock and reset
  input wire logic                         mclk_i,
  input wire logic                         rst_n_i,
  // Arbiter side
  input wire logic                         bus_hold_request_o,
  input wire logic                         bus_hold_grant_i,
  // Bus and FIFO
  input wire disk_dma_pkg::host_bus_out_t  host_bus_o,
  input wire disk_dma_pkg::fifo_ctl_t      fifo_o,
  // Host notification
  input wire logic                         launch_transfer_cmd_o,
  input wire logic                         transfer_running_flag_o,
  input wire logic                         host_irq_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Address phase is one T-state of four clocks, then data
  sequence addr_phase;
    (!host_bus_o.addr_data_n) [*4] ##1 host_bus_o.addr_data_n;
  endsequence

  // Timing and ownership of bus cycles
  a_addr_tstate: assert property (
    $fell(host_bus_o.addr_data_n) |-> addr_phase)
    else $error("address phase not one T-state");
  a_addr_driven: assert property (
    !host_bus_o.addr_data_n |-> host_bus_o.ad_oe && bus_hold_request_o)
    else $error("address phase without bus ownership");
  a_cycle_held: assert property (
    host_bus_o.status_lines != `SLINES_PASSIVE
      |-> bus_hold_request_o && transfer_running_flag_o)
    else $error("bus cycle without hold request");
  a_grant_vacate: assert property (
    $fell(bus_hold_grant_i) && bus_hold_request_o
      |-> ##[1:80] !bus_hold_request_o)
    else $error("bus not vacated after grant loss");

  // FIFO strobes sit at the right points of a cycle
  a_prefetch_pulse: assert property (
    fifo_o.rd |-> host_bus_o.addr_data_n
      && host_bus_o.status_lines != `SLINES_PASSIVE ##1 !fifo_o.rd)
    else $error("fifo read outside data phase");
  a_fifo_wr_t4: assert property (
    fifo_o.wr |-> $past(host_bus_o.status_lines) == `SLINES_MEM_READ)
    else $error("fifo write not after memory read");

  // Start, run flag and completion
  a_launch_pulse: assert property (
    launch_transfer_cmd_o |=> !launch_transfer_cmd_o)
    else $error("launch longer than one clock");
  a_launch_run: assert property (
    launch_transfer_cmd_o |-> ##[0:1] transfer_running_flag_o)
    else $error("run flag not set on launch");
  a_run_end_irq: assert property (
    $fell(transfer_running_flag_o) |-> ##[0:1] host_irq_o)
    else $error("transfer ended without interrupt");
  a_done_release: assert property (
    $rose(host_irq_o) |-> !bus_hold_request_o)
    else $error("hold kept at interrupt");
endmodule : disk_dma_seq_assertions

// ===== verification/arb_mem_model.sv
`include "disk_dma_params.svh"

module arb_mem_model
  import disk_dma_pkg::*;
(
  // Clock and reset
  input  wire logic                         mclk_i,
  input  wire logic                         rst_n_i,
  // Bench controls
  input  wire logic                         revoke_i,
  input  wire logic [7:0]                   slow_i,
  // Sequencer side
  input  wire logic                         hold_i,
  input  wire disk_dma_pkg::host_bus_out_t  bus_i,
  output logic                              grant_o,
  output logic                              ready_o,
  output logic [15:0]                       ad_o
);
  logic [7:0]  lag;
  logic [7:0]  low_cnt;
  logic [23:0] cyc_addr;

  // ready held low while memory is slow
  assign ready_o = (low_cnt == 8'h00);

  // Arbitration delay, memory latency and read data
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      lag      <= 8'h00;
      grant_o  <= 1'b0;
      low_cnt  <= 8'h00;
      cyc_addr <= 24'h000000;
      ad_o     <= 16'h0000;
    end
    else
    begin
      // grant withheld on revoke, never before a short delay
      lag      <= hold_i ? lag + {7'h00, lag < 8'h03} : 8'h00;
      grant_o  <= hold_i && !revoke_i && (lag == 8'h03);
      if (!bus_i.addr_data_n)
      begin
        cyc_addr <= {bus_i.addr_hi, bus_i.ad};
        low_cnt  <= slow_i;
      end
      else if (low_cnt != 8'h00)
        low_cnt <= low_cnt - 8'h01;
      // Data only once ready; else a changing pattern, no stale value
      if (bus_i.status_lines == `SLINES_MEM_READ && ready_o)
        ad_o <= cyc_addr[15:0] ^ 16'hc3c3;
      else
        ad_o <= ~ad_o;
    end
  end
endmodule : arb_mem_model

// ===== verification/tb_disk_fifo_dma_sequencer.sv
`include "disk_dma_params.svh"

module tb_disk_fifo_dma_sequencer
  import disk_dma_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // Driven inputs
  logic        mclk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        other_master_req_i = 1'b0;
  logic        fifo_full_i = 1'b0;
  logic        fifo_empty_i = 1'b0;
  logic [15:0] fifo_rdata_i = 16'h5a01;
  logic        revoke = 1'b0;
  logic [7:0]  slow = 8'h00;
  // Observed outputs
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, bus_hold_request_o, bus_hold_grant_i;
  logic memory_ready_in_i, launch_transfer_cmd_o;
  logic transfer_running_flag_o, host_irq_o, pad, ph;
  logic [1:0]    s_axi_bresp, s_axi_rresp, rs;
  logic [31:0]   s_axi_rdata, d;
  logic [15:0]   ad_i, wd, h;
  logic [2:0]    ps;
  host_bus_out_t host_bus_o;
  fifo_ctl_t     fifo_o;
  logic [31:0]   aq[$], mq[$], fq[$], dq[$];
  int bad_count = 0;
  int n_checks = 0;
  int launches, rds, drops, gap;
  int act = 0;

  disk_fifo_dma_sequencer #(.TICK_CYCLES(4)) i_dut (
    .mclk_i, .rst_n_i, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .bus_hold_request_o, .bus_hold_grant_i,
    .other_master_req_i, .memory_ready_in_i, .host_bus_o, .ad_i,
    .fifo_full_i, .fifo_empty_i, .fifo_rdata_i, .fifo_o,
    .launch_transfer_cmd_o, .transfer_running_flag_o, .host_irq_o);

  arb_mem_model i_mem (.mclk_i, .rst_n_i, .revoke_i(revoke),
    .slow_i(slow), .hold_i(bus_hold_request_o), .bus_i(host_bus_o),
    .grant_o(bus_hold_grant_i), .ready_o(memory_ready_in_i), .ad_o(ad_i));

  always #20 mclk_i = ~mclk_i;

  // Bus watch; FIFO head advances on each read strobe
  always @(posedge mclk_i)
  begin
    if (launch_transfer_cmd_o === 1'b1) launches++;
    if (fifo_o.rd === 1'b1)
    begin
      rds++;
      fifo_rdata_i <= fifo_rdata_i + 16'h1111;
    end
    if (fifo_o.wr === 1'b1) fq.push_back(32'(fifo_o.wdata));
    if (host_bus_o.addr_data_n === 1'b0 && pad === 1'b1)
      aq.push_back({8'h00, host_bus_o.addr_hi, host_bus_o.ad});
    if (host_bus_o.status_lines === `SLINES_MEM_WRITE) wd = host_bus_o.ad;
    if (host_bus_o.status_lines !== `SLINES_PASSIVE) act++;
    else if (act != 0)
    begin
      dq.push_back(act);
      if (ps === `SLINES_MEM_WRITE) mq.push_back(32'(wd));
      act = 0;
    end
    if (!bus_hold_request_o && ph && transfer_running_flag_o) drops++;
    pad = host_bus_o.addr_data_n;
    ps = host_bus_o.status_lines;
    ph = bus_hold_request_o;
  end

  task automatic conclude;
    if (bad_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  task automatic fail(input string m);
    bad_count++;
    $display("unexpected at %0t: %s timed out", $time, m);
    conclude();
  endtask : fail

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk

  // Write: address and data offered together, each released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    int n;
    @(posedge mclk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50 && !(s_axi_bvalid && s_axi_bready); n++)
    begin
      @(posedge mclk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 50) fail("axi write");
  endtask : axw

  task automatic axr(input logic [7:0] a);
    int n;
    @(posedge mclk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50 && !(s_axi_rvalid && s_axi_rready); n++)
    begin
      @(posedge mclk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    d = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 50) fail("axi read");
  endtask : axr

  // Wait for interrupt (irq=1) or hold request to reach a level
  task automatic wait_sig(input bit irq, input logic lvl);
    for (gap = 0; gap < 20000; gap++)
    begin
      @(posedge mclk_i);
      if ((irq ? host_irq_o : bus_hold_request_o) === lvl) break;
    end
    if (gap == 20000) fail("signal wait");
  endtask : wait_sig

  task automatic wait_q(ref logic [31:0] q[$]);
    int n;
    for (n = 0; n < 4000 && q.size() == 0; n++) @(posedge mclk_i);
    if (n == 4000) fail("queue wait");
  endtask : wait_q

  task automatic prog(input logic dir, input logic [15:0] cnt,
                      input logic [23:0] a);
    aq.delete();
    mq.delete();
    fq.delete();
    dq.delete();
    launches = 0;
    rds = 0;
    drops = 0;
    axw(`REG_ADDR_OFS, {8'h00, a});
    axw(`REG_COUNT_OFS, {16'h0000, cnt});
    axw(`REG_CTRL_OFS, {31'h0, dir});
    axw(`REG_CTRL_OFS, {30'h0, 1'b1, dir});
  endtask : prog

  initial
  begin
    repeat (8) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    axr(`REG_STATUS_OFS);
    chk(d, 32'h0, "status after reset");
    axr(8'h10);
    chk(32'(rs), 32'(`RESP_SLVERR), "unmapped read");
    axw(8'h14, 32'h1);
    chk(32'(rs), 32'(`RESP_SLVERR), "unmapped write");
    // Three words across 64K, FIFO empty first
    h = fifo_rdata_i;
    fifo_empty_i <= 1'b1;
    prog(1'b0, 16'hfffd, 24'h12fffe);
    chk(32'(rs), 32'(`RESP_OKAY), "write resp");
    axr(`REG_ADDR_OFS);
    chk(d, 32'h0012fffe, "addr readback");
    repeat (40) @(posedge mclk_i);
    chk(32'(launches), 32'h1, "launch");
    chk({31'h0, transfer_running_flag_o}, 32'h1, "run");
    chk({31'h0, bus_hold_request_o}, 32'h0, "hold on empty");
    fifo_empty_i <= 1'b0;
    wait_sig(1'b1, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      chk(aq[i], 32'h12fffe + i, "word address");
      chk(mq[i], 32'(h + 16'(i) * 16'h1111), "mem data");
      chk(dq[i], 32'd12, "cycle length");
    end
    axr(`REG_STATUS_OFS);
    chk(d & 32'h1fe, 32'h4, "done idle");
    axw(`REG_CTRL_OFS, 32'h4);
    chk({31'h0, host_irq_o}, 32'h0, "irq clear");
    // Slow memory to FIFO, other master cuts in
    slow <= 8'h0a;
    prog(1'b1, 16'hfffe, 24'h00a0f0);
    other_master_req_i <= 1'b1;
    wait_q(fq);
    repeat (40) @(posedge mclk_i);
    other_master_req_i <= 1'b0;
    wait_sig(1'b1, 1'b1);
    for (int i = 0; i < 2; i++)
      chk(fq[i], 32'(16'ha0f0 + 16'(i)) ^ 32'hc3c3, "fifo data");
    chk(32'(dq[0] % 4 == 0 && dq[0] > 12), 32'h1, "waits");
    chk(32'(drops), 32'h1, "bus yielded");
    axw(`REG_CTRL_OFS, 32'h4);
    // Grant withdrawn during the first word
    slow <= 8'h00;
    prog(1'b0, 16'hfffe, 24'h000100);
    wait_q(aq);
    revoke <= 1'b1;
    wait_sig(1'b0, 1'b0);
    wait_sig(1'b0, 1'b1);
    chk(32'(gap >= 7 && gap <= 20), 32'h1, "re-request");
    revoke <= 1'b0;
    wait_sig(1'b1, 1'b1);
    chk(32'(mq.size()), 32'h2, "words after resume");
    axw(`REG_CTRL_OFS, 32'h4);
    // Full and empty together mid-transfer
    prog(1'b0, 16'hfff0, 24'h000000);
    wait_sig(1'b0, 1'b1);
    fifo_full_i <= 1'b1;
    fifo_empty_i <= 1'b1;
    wait_sig(1'b1, 1'b1);
    fifo_full_i <= 1'b0;
    fifo_empty_i <= 1'b0;
    chk({30'h0, transfer_running_flag_o, bus_hold_request_o}, 32'h0,
        "stopped");
    axr(`REG_STATUS_OFS);
    chk(32'({d[8], d[3:0]}), 32'h1a, "error flag");
    axw(`REG_CTRL_OFS, 32'h2);
    repeat (40) @(posedge mclk_i);
    chk(32'(launches), 32'h1, "start refused");
    axw(`REG_CTRL_OFS, 32'h4);
    axr(`REG_STATUS_OFS);
    chk({d[8], 30'h0, host_irq_o}, 32'h0, "error cleared");
    // Counts of 0 and 257 words refused, 256 accepted
    for (int i = 0; i < 3; i++)
    begin
      prog(1'b0, i == 0 ? 16'h0 : i == 1 ? 16'hfeff : 16'hff00, 24'h0);
      wait_sig(1'b1, 1'b1);
      axr(`REG_STATUS_OFS);
      chk(32'(d[8]), 32'(i < 2), "count limit");
      chk(32'(rds), i < 2 ? 32'h0 : 32'd256, "words moved");
      axw(`REG_CTRL_OFS, 32'h4);
    end
    conclude();
  end
endmodule : tb_disk_fifo_dma_sequencer

bind disk_fifo_dma_sequencer disk_dma_seq_assertions #(
  .TICK_CYCLES(TICK_CYCLES)
) i_chk (.mclk_i, .rst_n_i, .bus_hold_request_o, .bus_hold_grant_i,
  .host_bus_o, .fifo_o, .launch_transfer_cmd_o, .transfer_running_flag_o,
  .host_irq_o);
